/* File: rtl/csr_clock_sysref_regs.sv */
// Purpose: APB register block for sample clock detect, duty cycle stabilizers, reference capture
// Assumes: One pclk domain; sample_clk and sysref arrive synchronous to pclk
// Notes:   One wait state per APB access; ce low freezes every register
`timescale 1ns/10ps
module csr_clock_sysref_regs #(
    parameter logic [csr_pkg::DET_W-1:0] DET_FAST = csr_pkg::DET_FAST_CYC,
    parameter logic [csr_pkg::DET_W-1:0] DET_SLOW = csr_pkg::DET_SLOW_CYC
) (
    // Clock, reset and enable
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [csr_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [csr_pkg::DATA_W-1:0]  pwdata,
    output logic      [csr_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Clock front end
    input  wire logic                        sample_clk,
    input  wire logic                        sysref,
    output logic                             clock_detected,
    output logic                             stab1_power_up,
    output logic                             stab1_enable,
    output logic                             stab2_power_up,
    output logic                             stab2_enable,
    output logic                             stab3_enable,
    // Reference capture and interrupt
    output logic                             ref_capture,
    output logic                             irq
);
    import csr_pkg::*;

    function automatic logic reg_mapped(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_CLK_DET, IDX_CLK_STAT, IDX_DCS1, IDX_DCS2, IDX_DCS3,
            IDX_REF_CTRL, IDX_REF_IGNORE, IDX_INT_STATUS, IDX_INT_ENABLE,
            IDX_INT_CLEAR, IDX_REF_FLAGS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] masked(input logic [7:0] old, input logic [7:0] wr,
                                          input logic [7:0] wm);
        return (old & ~wm) | (wr & wm);
    endfunction

    // Register state
    logic [7:0]       clk_det_ctrl;
    logic [7:0]       stab_one;
    logic [7:0]       stab_two;
    logic [7:0]       stab_three;
    logic [7:0]       ref_ctrl;
    logic [7:0]       ref_ignore;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_enable;
    logic [7:0]       next_clk_det_ctrl;
    logic [7:0]       next_stab_one;
    logic [7:0]       next_stab_two;
    logic [7:0]       next_stab_three;
    logic [7:0]       next_ref_ctrl;
    logic [7:0]       next_ref_ignore;
    logic [INT_W-1:0] next_int_status;
    logic [INT_W-1:0] next_int_enable;
    logic             next_stab3_enable;
    logic             next_irq;
    // Bus state
    logic [DATA_W-1:0] next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    // Clock detect state
    logic              sample_clk_q;
    logic [DET_W-1:0]  det_cnt;
    logic [DET_W-1:0]  next_det_cnt;
    logic [DET_W-1:0]  det_limit;
    logic              next_clock_detected;
    // Decode and events
    logic [IDX_W-1:0]  idx;
    logic              hit;
    logic              wr_done;
    logic [7:0]        rd_byte;
    logic [INT_W-1:0]  int_clr;
    logic [INT_W-1:0]  int_evt;
    logic              arm;
    logic              setup_err;
    logic              hold_err;
    logic              clk_edge;

    // APB decode; registers change only at the edge that completes the access
    always_comb begin
        idx     = paddr[ADDR_W-1:2];
        hit     = reg_mapped(idx) && (paddr[1:0] == 2'h0);
        wr_done = psel && penable && pready && pwrite && hit;
        case (idx)
            IDX_CLK_DET:    rd_byte = clk_det_ctrl;
            IDX_CLK_STAT:   rd_byte = {7'h00, clock_detected};
            IDX_DCS1:       rd_byte = stab_one;
            IDX_DCS2:       rd_byte = stab_two;
            IDX_DCS3:       rd_byte = stab_three;
            IDX_REF_CTRL:   rd_byte = ref_ctrl & WM_REF_CTRL;
            IDX_REF_IGNORE: rd_byte = ref_ignore & WM_REF_IGNORE;
            IDX_INT_STATUS: rd_byte = {4'h0, int_status};
            IDX_INT_ENABLE: rd_byte = {4'h0, int_enable};
            IDX_REF_FLAGS:  rd_byte = {6'h00, hold_err, setup_err};
            default:        rd_byte = 8'h00;
        endcase
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            next_pready  = 1'b1;
            next_prdata  = {24'h000000, rd_byte};
            next_pslverr = !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Register writes; masks keep read-only and reserved bits at reset value
    always_comb begin
        next_clk_det_ctrl = clk_det_ctrl;
        next_stab_one     = stab_one;
        next_stab_two     = stab_two;
        next_stab_three   = stab_three;
        next_ref_ctrl     = ref_ctrl;
        next_ref_ignore   = ref_ignore;
        next_int_enable   = int_enable;
        int_clr           = 4'h0;
        arm               = 1'b0;
        if (wr_done) begin
            case (idx)
                IDX_CLK_DET:    next_clk_det_ctrl = masked(clk_det_ctrl, pwdata[7:0],
                                                           WM_CLK_DET);
                IDX_DCS1:       next_stab_one = masked(stab_one, pwdata[7:0], WM_DCS);
                IDX_DCS2:       next_stab_two = masked(stab_two, pwdata[7:0], WM_DCS);
                IDX_DCS3:       next_stab_three = masked(stab_three, pwdata[7:0], WM_DCS3);
                IDX_REF_CTRL: begin
                    next_ref_ctrl = masked(ref_ctrl, pwdata[7:0], WM_REF_CTRL);
                    // Each write that selects counted mode re-arms the capture
                    arm = (pwdata[MODE_LSB+:2] == MODE_COUNTED);
                end
                IDX_REF_IGNORE: next_ref_ignore = masked(ref_ignore, pwdata[7:0],
                                                         WM_REF_IGNORE);
                IDX_INT_ENABLE: next_int_enable = pwdata[INT_W-1:0];
                IDX_INT_CLEAR:  int_clr = pwdata[INT_W-1:0];
                default:        next_int_enable = int_enable;
            endcase
        end
        next_stab3_enable = (next_stab_three == DCS3_ON);
        next_irq          = |(next_int_status & next_int_enable);
    end

    // Sticky interrupt bits: an event in the clearing cycle wins
    always_comb begin
        int_evt              = 4'h0;
        int_evt[INT_CAPTURE] = ref_capture;
        int_evt[INT_SETUP]   = setup_err;
        int_evt[INT_HOLD]    = hold_err;
        int_evt[INT_CLK]     = clock_detected ^ next_clock_detected;
    end

    genvar g;
    generate
        for (g = 0; g < INT_W; g++) begin : g_sticky
            assign next_int_status[g] = int_evt[g] | (int_status[g] & ~int_clr[g]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_det_ctrl <= RST_CLK_DET;
            stab_one     <= RST_DCS1;
            stab_two     <= RST_DCS2;
            stab_three   <= RST_DCS3;
            ref_ctrl     <= RST_REF_CTRL;
            ref_ignore   <= RST_REF_IGNORE;
            int_status   <= RST_INT;
            int_enable   <= RST_INT;
            stab3_enable <= 1'b0;
            irq          <= 1'b0;
        end else if (ce) begin
            clk_det_ctrl <= next_clk_det_ctrl;
            stab_one     <= next_stab_one;
            stab_two     <= next_stab_two;
            stab_three   <= next_stab_three;
            ref_ctrl     <= next_ref_ctrl;
            ref_ignore   <= next_ref_ignore;
            int_status   <= next_int_status;
            int_enable   <= next_int_enable;
            stab3_enable <= next_stab3_enable;
            irq          <= next_irq;
        end
    end

    // Stabilizer one and two controls drive the front end straight from their bits
    assign stab1_power_up = stab_one[DCS_PWR_BIT];
    assign stab1_enable   = stab_one[DCS_EN_BIT];
    assign stab2_power_up = stab_two[DCS_PWR_BIT];
    assign stab2_enable   = stab_two[DCS_EN_BIT];

    // Clock detect: lost once no sample clock edge is seen within the timeout
    always_comb begin
        clk_edge            = sample_clk ^ sample_clk_q;
        det_limit           = (clk_det_ctrl[THR_LSB+:2] == THR_SLOW) ? DET_SLOW : DET_FAST;
        next_det_cnt        = det_cnt;
        next_clock_detected = clock_detected;
        if (clk_edge) begin
            next_det_cnt        = {DET_W{1'b0}};
            next_clock_detected = 1'b1;
        end else begin
            if (det_cnt < det_limit) begin
                next_det_cnt = det_cnt + 8'h01;
            end
            if (det_cnt >= det_limit - 8'h01) begin
                next_clock_detected = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_clk_q   <= 1'b0;
            det_cnt        <= {DET_W{1'b0}};
            clock_detected <= 1'b0;
        end else if (ce) begin
            sample_clk_q   <= sample_clk;
            det_cnt        <= next_det_cnt;
            clock_detected <= next_clock_detected;
        end
    end

    csr_ref_capture u_capture (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .sample_clk   (sample_clk),
        .sample_clk_q (sample_clk_q),
        .sysref       (sysref),
        .edge_sel     (ref_ctrl[EDGE_BIT]),
        .trans_sel    (ref_ctrl[TRANS_BIT]),
        .mode         (ref_ctrl[MODE_LSB+:2]),
        .flag_reset   (ref_ctrl[FLAG_RST_BIT]),
        .ignore_count (ref_ignore[3:0]),
        .arm          (arm),
        .capture      (ref_capture),
        .setup_err    (setup_err),
        .hold_err     (hold_err)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    thr_timeout_a: assert property ($fell(clock_detected) |->
        ($past(clk_det_ctrl[THR_LSB+:2]) == THR_SLOW ? $past(det_cnt) >= DET_SLOW - 8'h01
                                                     : $past(det_cnt) >= DET_FAST - 8'h01))
        else $error("clock lost before threshold timeout");
    clk_seen_a: assert property (ce && (sample_clk ^ sample_clk_q) |=> clock_detected)
        else $error("clock edge did not set detect status");
    stab_write_a: assert property (ce && wr_done && idx == IDX_DCS1 |=>
        stab1_power_up == $past(pwdata[DCS_PWR_BIT]) && stab1_enable == $past(pwdata[DCS_EN_BIT]))
        else $error("stabilizer one write not applied");
    stab_two_a: assert property (ce && wr_done && idx == IDX_DCS2 |=>
        stab2_power_up == $past(pwdata[DCS_PWR_BIT]) && stab2_enable == $past(pwdata[DCS_EN_BIT]))
        else $error("stabilizer two write not applied");
    det_event_a: assert property (ce && (clock_detected != next_clock_detected)
        |=> int_status[INT_CLK])
        else $error("detect change did not set its status bit");
    reserved_read_a: assert property (psel && penable && pready && !pwrite
        && idx == IDX_REF_CTRL |-> prdata[7] == 1'b0 && prdata[5] == 1'b0 && prdata[0] == 1'b0)
        else $error("read-only reserved reference bits not zero");
    irq_level_a: assert property (irq == |(int_status & int_enable))
        else $error("interrupt output disagrees with enabled status");

    irq_rise_c: cover property ($rose(irq));
    clk_lost_c: cover property ($fell(clock_detected));

endmodule // csr_clock_sysref_regs

/* File: rtl/csr_pkg.sv */
// Purpose: Shared constants for the sample clock and reference capture control block
// Assumes: APB word registers at byte address four times the register index
// Notes:   Index, reset value, write mask and field position each named once here
package csr_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 10;
    localparam int INT_W  = 4;
    localparam int DET_W  = 8;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_CLK_DET    = 10'h11A;
    localparam logic [IDX_W-1:0] IDX_CLK_STAT   = 10'h11B;
    localparam logic [IDX_W-1:0] IDX_DCS1       = 10'h11C;
    localparam logic [IDX_W-1:0] IDX_DCS2       = 10'h11E;
    localparam logic [IDX_W-1:0] IDX_DCS3       = 10'h11F;
    localparam logic [IDX_W-1:0] IDX_REF_CTRL   = 10'h120;
    localparam logic [IDX_W-1:0] IDX_REF_IGNORE = 10'h121;
    localparam logic [IDX_W-1:0] IDX_INT_STATUS = 10'h130;
    localparam logic [IDX_W-1:0] IDX_INT_ENABLE = 10'h131;
    localparam logic [IDX_W-1:0] IDX_INT_CLEAR  = 10'h132;
    localparam logic [IDX_W-1:0] IDX_REF_FLAGS  = 10'h133;

    // Reset values
    localparam logic [7:0] RST_CLK_DET    = 8'h09;
    localparam logic [7:0] RST_DCS1       = 8'h08;
    localparam logic [7:0] RST_DCS2       = 8'h88;
    localparam logic [7:0] RST_DCS3       = 8'h84;
    localparam logic [7:0] RST_REF_CTRL   = 8'h00;
    localparam logic [7:0] RST_REF_IGNORE = 8'h00;
    localparam logic [3:0] RST_INT        = 4'h0;

    // Writable bits
    localparam logic [7:0] WM_CLK_DET    = 8'hFF;
    localparam logic [7:0] WM_DCS        = 8'hFB;
    localparam logic [7:0] WM_DCS3       = 8'hFF;
    localparam logic [7:0] WM_REF_CTRL   = 8'h5E;
    localparam logic [7:0] WM_REF_IGNORE = 8'h0F;

    // Field positions
    localparam int THR_LSB      = 3;
    localparam int DCS_PWR_BIT  = 0;
    localparam int DCS_EN_BIT   = 1;
    localparam int FLAG_RST_BIT = 6;
    localparam int TRANS_BIT    = 4;
    localparam int EDGE_BIT     = 3;
    localparam int MODE_LSB     = 1;

    // Field codes
    localparam logic [1:0] THR_FAST     = 2'h1;
    localparam logic [1:0] THR_SLOW     = 2'h3;
    localparam logic [7:0] DCS3_ON      = 8'h81;
    localparam logic [1:0] MODE_OFF     = 2'h0;
    localparam logic [1:0] MODE_CONT    = 2'h2 - 2'h1;
    localparam logic [1:0] MODE_COUNTED = 2'h2;

    // Interrupt bit positions
    localparam int INT_CAPTURE = 0;
    localparam int INT_SETUP   = 1;
    localparam int INT_HOLD    = 2;
    localparam int INT_CLK     = 3;

    // Clock loss timeouts in pclk cycles without a sample clock edge
    localparam logic [DET_W-1:0] DET_FAST_CYC = 8'h10;
    localparam logic [DET_W-1:0] DET_SLOW_CYC = 8'h40;

    typedef enum logic {ns_idle, ns_armed} csr_nshot_t;

endpackage

/* File: rtl/csr_ref_capture.sv */
// Purpose: Reference capture on the chosen sample clock edge, with setup and hold flags
// Assumes: sample_clk and sysref are synchronous to pclk; sample_clk_q is its last sample
// Notes:   Counted mode arms on the arm pulse and captures once
`timescale 1ns/10ps
module csr_ref_capture (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Link side samples
    input  wire logic       sample_clk,
    input  wire logic       sample_clk_q,
    input  wire logic       sysref,
    // Configuration
    input  wire logic       edge_sel,
    input  wire logic       trans_sel,
    input  wire logic [1:0] mode,
    input  wire logic       flag_reset,
    input  wire logic [3:0] ignore_count,
    input  wire logic       arm,
    // Results
    output logic            capture,
    output logic            setup_err,
    output logic            hold_err
);
    import csr_pkg::*;

    logic       ref_q;
    logic       ref_cap;
    logic       hold_chk;
    logic [3:0] skip_cnt;
    csr_nshot_t state;
    logic       next_ref_q;
    logic       next_ref_cap;
    logic       next_hold_chk;
    logic [3:0] next_skip_cnt;
    csr_nshot_t next_state;
    logic       next_capture;
    logic       next_setup_err;
    logic       next_hold_err;
    logic       cap_edge;
    logic       valid_tr;

    always_comb begin
        cap_edge = edge_sel ? (sample_clk_q & ~sample_clk) : (~sample_clk_q & sample_clk);
        valid_tr = trans_sel ? (ref_cap & ~sysref) : (~ref_cap & sysref);
        next_ref_q     = sysref;
        next_ref_cap   = cap_edge ? sysref : ref_cap;
        next_hold_chk  = cap_edge;
        next_state     = state;
        next_skip_cnt  = skip_cnt;
        next_capture   = 1'b0;
        if (mode == MODE_CONT && cap_edge && valid_tr) begin
            next_capture = 1'b1;
        end
        case (state)
            ns_idle: begin
                next_state = ns_idle;
            end
            ns_armed: begin
                if (mode != MODE_COUNTED) begin
                    next_state = ns_idle;
                end else if (cap_edge && valid_tr) begin
                    if (skip_cnt == 4'h0) begin
                        next_capture = 1'b1;
                        next_state   = ns_idle;
                    end else begin
                        next_skip_cnt = skip_cnt - 4'h1;
                    end
                end
            end
            default: next_state = ns_idle;
        endcase
        if (arm) begin
            next_state    = ns_armed;
            next_skip_cnt = ignore_count;
        end
        // Flag reset holds the flags clear, so it beats a coincident error
        if (flag_reset) begin
            next_setup_err = 1'b0;
            next_hold_err  = 1'b0;
        end else begin
            next_setup_err = setup_err | (cap_edge & (sysref ^ ref_q));
            next_hold_err  = hold_err | (hold_chk & (sysref ^ ref_cap));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q     <= 1'b0;
            ref_cap   <= 1'b0;
            hold_chk  <= 1'b0;
            skip_cnt  <= 4'h0;
            state     <= ns_idle;
            capture   <= 1'b0;
            setup_err <= 1'b0;
            hold_err  <= 1'b0;
        end else if (ce) begin
            ref_q     <= next_ref_q;
            ref_cap   <= next_ref_cap;
            hold_chk  <= next_hold_chk;
            skip_cnt  <= next_skip_cnt;
            state     <= next_state;
            capture   <= next_capture;
            setup_err <= next_setup_err;
            hold_err  <= next_hold_err;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    edge_pick_a: assert property (capture && $past(ce) |->
        $past(edge_sel ? (sample_clk_q & ~sample_clk) : (~sample_clk_q & sample_clk)))
        else $error("capture not on the selected clock edge");
    valid_dir_a: assert property (capture && $past(ce) |->
        $past(trans_sel ? (ref_cap & ~sysref) : (~ref_cap & sysref)))
        else $error("capture on a transition of the wrong direction");
    mode_off_a: assert property ($past(ce) && $past(mode) == MODE_OFF |-> !capture)
        else $error("capture while reference mode is disabled");
    flag_clear_a: assert property (ce && flag_reset |=> !setup_err && !hold_err)
        else $error("setup or hold flag set during flag reset");
    skip_done_a: assert property (capture && $past(ce) && $past(mode) == MODE_COUNTED
        |-> $past(skip_cnt) == 4'h0 && $past(state) == ns_armed)
        else $error("counted capture before ignore count ran out");
    arm_load_a: assert property (ce && arm |=> state == ns_armed
        && skip_cnt == $past(ignore_count))
        else $error("arming did not load the ignore count");

    cont_cap_c: cover property (mode == MODE_CONT ##1 capture);
    count_cap_c: cover property (arm && ignore_count == 4'h2 ##[1:200] capture);

endmodule // csr_ref_capture

/* File: sim/csr_clkgen.sv */
// Purpose: Clock source model driving sample clock and reference level
// Assumes: Both outputs change only on pclk rising edges
// Notes:   Reference moves mid phase; with late set it moves on the clock toggle itself
`timescale 1ns/10ps
module csr_clkgen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic       want,
    input  wire logic       late,
    input  wire logic [3:0] half,
    output logic            sample_clk,
    output logic            sysref
);
    logic [3:0] cnt;
    // Clock stands still while run is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt        <= 4'h0;
            sample_clk <= 1'b0;
            sysref     <= 1'b0;
        end else if (run) begin
            cnt <= (cnt == half - 4'h1) ? 4'h0 : cnt + 4'h1;
            if (cnt == half - 4'h1) sample_clk <= ~sample_clk;
            // Late timing lands the reference change on the edge, a setup violation
            if (cnt == (late ? half - 4'h1 : (half >> 1))) sysref <= want;
        end
    end
endmodule // csr_clkgen

/* File: sim/clock_sysref_control_regs_bench.sv */
// Purpose: Register, detect, interrupt and reference capture tests
// Assumes: One wait state APB slave, ce tied high
// Notes:   Small detect timeouts keep the run short
`timescale 1ns/10ps
module clock_sysref_control_regs_bench;
    import csr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, want = 0, late = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [3:0] half = 4'h4;
    logic pready, pslverr, sclk, sref, det, p1, e1, p2, e2, e3, cap, irq, e;
    int errors = 0, n_checks = 0, ncap = 0;
    csr_clkgen gen (.pclk(pclk), .presetn(presetn), .run(run), .want(want), .half(half),
                    .late(late), .sample_clk(sclk), .sysref(sref));
    csr_clock_sysref_regs #(.DET_FAST(8'h08), .DET_SLOW(8'h10)) DUT (.pclk(pclk),
        .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_clk(sclk), .sysref(sref), .clock_detected(det), .stab1_power_up(p1),
        .stab1_enable(e1), .stab2_power_up(p2), .stab2_enable(e2), .stab3_enable(e3),
        .ref_capture(cap), .irq(irq));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (cap === 1'b1) ncap++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) errors++;
        r = prdata; e = pslverr; psel <= 0; penable <= 0;
        // One idle edge so that a write's effect stands before it is checked
        @(posedge pclk);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
        apb(0, idx, 8'h00);
        chk(r, {24'h0, exp});
        chk(e, (idx > 10'h133 || idx < 10'h11A) ? 1 : 0);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            want <= 1; repeat (20) @(posedge pclk);
            want <= 0; repeat (20) @(posedge pclk);
        end
    endtask
    task summarize;
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #300us; errors++; summarize; end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        rd(IDX_CLK_DET, 8'h09); rd(IDX_DCS1, 8'h08); rd(IDX_DCS2, 8'h88);
        rd(IDX_DCS3, 8'h84); rd(IDX_REF_CTRL, 8'h00); rd(IDX_CLK_STAT, 8'h00);
        rd(10'h000, 8'h00);
        apb(1, IDX_REF_CTRL, 8'hFF); rd(IDX_REF_CTRL, 8'h5E);
        apb(1, IDX_REF_CTRL, 8'hF9); apb(1, IDX_REF_CTRL, 8'h00);
        // Power up first, then enable; second copy kept equal to first
        apb(1, IDX_DCS1, 8'h09); apb(1, IDX_DCS2, 8'h09);
        chk({e1, p1, e2, p2}, 4'h5);
        apb(1, IDX_DCS1, 8'h0B); apb(1, IDX_DCS2, 8'h0B);
        chk({e1, p1, e2, p2}, 4'hF); rd(IDX_DCS2, 8'h0B);
        apb(1, IDX_DCS3, DCS3_ON); chk(e3, 1);
        apb(1, IDX_INT_ENABLE, 8'h08); run <= 1; repeat (30) @(posedge pclk);
        chk({det, irq}, 2'b11); rd(IDX_CLK_STAT, 8'h01);
        apb(1, IDX_INT_ENABLE, 8'h00); @(posedge pclk); @(posedge pclk); chk(irq, 0);
        run <= 0; repeat (30) @(posedge pclk); rd(IDX_CLK_STAT, 8'h00);
        apb(1, IDX_INT_CLEAR, 8'h08); rd(IDX_INT_STATUS, 8'h00);
        apb(1, IDX_INT_ENABLE, 8'h08); @(posedge pclk); @(posedge pclk); chk(irq, 0);
        // Slow threshold tolerates a gap that the fast one does not
        apb(1, IDX_CLK_DET, 8'h19); half <= 4'hC; run <= 1;
        repeat (80) @(posedge pclk); rd(IDX_CLK_STAT, 8'h01);
        apb(1, IDX_INT_CLEAR, 8'h08); repeat (30) @(posedge pclk);
        rd(IDX_INT_STATUS, 8'h00);
        // Fast threshold loses a clock this slow, so detect keeps toggling
        apb(1, IDX_CLK_DET, 8'h09); repeat (40) @(posedge pclk);
        rd(IDX_INT_STATUS, 8'h08);
        half <= 4'h4; repeat (20) @(posedge pclk);
        apb(1, IDX_REF_CTRL, 8'h02); pulse(1); chk(ncap, 1);
        apb(1, IDX_REF_CTRL, 8'h00); apb(1, IDX_REF_CTRL, 8'h18);
        apb(1, IDX_REF_CTRL, 8'h1A); pulse(1); chk(ncap, 2);
        apb(1, IDX_REF_CTRL, 8'h18); apb(1, IDX_REF_CTRL, 8'h00);
        apb(1, IDX_REF_IGNORE, 8'h02);
        apb(1, IDX_REF_CTRL, 8'h04); pulse(4); chk(ncap, 3);
        apb(1, IDX_REF_CTRL, 8'h00); pulse(2); chk(ncap, 3);
        // A reference change on the capture edge must raise the setup flag
        late <= 1; pulse(1); late <= 0; rd(IDX_REF_FLAGS, 8'h01);
        apb(1, IDX_REF_CTRL, 8'h40); rd(IDX_REF_CTRL, 8'h40); rd(IDX_REF_FLAGS, 8'h00);
        summarize;
    end
endmodule // clock_sysref_control_regs_bench
